// File: inc/sleep_pkg.sv
// constants and types for the sleep mode and reset pin controller
package sleep_pkg;
	// ==========================================
	// sleep mode encodings and widths
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_ADC_NR,
		MODE_PWR_DOWN,
		MODE_PWR_SAVE,
		MODE_STANDBY
	} sleep_mode_t;
	localparam int          NUM_MODES      = 5;
	localparam int          PORT_B_WIDTH   = 8;
	localparam int          PORT_C_WIDTH   = 7;
	localparam int          PORT_D_WIDTH   = 8;
	localparam int          SHARED_PIN_BIT = 6;
	localparam int          TOSC1_BIT      = 6;
	localparam int          TOSC2_BIT      = 7;
	// ==========================================
	// timing
	localparam int          CLK_PERIOD_PS  = 4000;
	localparam int          MIN_RST_PULSE_NS = 1500;
	localparam int          MIN_RST_CYCLES =
		(MIN_RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [9:0]  RST_CNT_MAX    = 10'(MIN_RST_CYCLES);
	localparam logic [9:0]  RST_CNT_RESET  = 10'h000;
	localparam logic [7:0]  ZERO8          = 8'h00;
endpackage

// File: design/reset_pulse_filter.sv
// filter that turns a long enough low on the reset pin into a reset request
`timescale 1ns/1ps
module reset_pulse_filter
	import sleep_pkg::*;
(
	input  wire logic ref_clk,      // system clock
	input  wire logic rst_n,        // synchronised reset, active low
	input  wire logic clk_en,       // freezes state while low
	input  wire logic pin_low,      // synchronised low level on reset pin
	output logic      ext_reset     // long low seen
);
	logic [9:0] cnt_reg;
	logic [9:0] cnt_next;
	logic       hit_reg;
	logic       hit_next;

	always_comb begin
		cnt_next = cnt_reg;
		hit_next = hit_reg;
		if (!pin_low) begin
			cnt_next = RST_CNT_RESET;
			hit_next = 1'b0;
		end else if (cnt_reg >= RST_CNT_MAX - 10'h001) begin
			hit_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 10'h001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= RST_CNT_RESET;
			hit_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
			hit_reg <= hit_next;
		end
	end

	assign ext_reset = hit_reg;
endmodule

// File: design/sleep_reset_ctrl.sv
// sleep mode clock gating, reset pin handling and port pin control
`timescale 1ns/1ps
// Summary of operation
// - five selectable sleep modes: idle, power-down, power-save, ADC noise, standby
// - idle halts the processor; SRAM, timers, SPI, interrupts keep running
// - power-down stops oscillator and all functions until interrupt or reset
// - power-save keeps the async timer running, rest as power-down
// - ADC noise mode stops processor and I/O except async timer and ADC
// - standby keeps the main oscillator running, rest sleeps
// - rst_n tri-states all port pins at once; a reset pin reset does so only on an enabled clock edge
// - reset pin low longer than minimum pulse causes reset
// - fuse programmed makes the shared pin plain I/O, else reset input
// - RC clock with async select routes two upper port B pins to timer oscillator
// - ports B and D have 8 pins, port C 7, each with pull-up
module sleep_reset_ctrl
	import sleep_pkg::*;
(
	input  wire logic                    ref_clk,             // system clock
	input  wire logic                    rst_n,               // async reset, active low
	input  wire logic                    clk_en,              // freezes state while low
	input  wire logic                    sleep_req,           // core executes sleep
	input  wire logic [2:0]              sleep_mode_sel,      // selected sleep mode
	input  wire logic                    wake_irq,            // pending wake interrupt
	input  wire logic                    reset_pin_disable_fuse, // shared pin is plain I/O
	input  wire logic                    int_rc_clock,        // chip runs on internal RC
	input  wire logic                    async_timer_clock_select, // async timer on pins
	input  wire logic [PORT_B_WIDTH-1:0] port_b_in,           // port B pin levels
	input  wire logic [PORT_C_WIDTH-1:0] port_c_in,           // port C pin levels
	input  wire logic [PORT_D_WIDTH-1:0] port_d_in,           // port D pin levels
	input  wire logic [PORT_B_WIDTH-1:0] port_b_out,          // port B drive value
	input  wire logic [PORT_B_WIDTH-1:0] port_b_dir,          // port B drive enable
	input  wire logic [PORT_B_WIDTH-1:0] port_b_pull,         // port B pull-up request
	input  wire logic [PORT_C_WIDTH-1:0] port_c_out,          // port C drive value
	input  wire logic [PORT_C_WIDTH-1:0] port_c_dir,          // port C drive enable
	input  wire logic [PORT_C_WIDTH-1:0] port_c_pull,         // port C pull-up request
	input  wire logic [PORT_D_WIDTH-1:0] port_d_out,          // port D drive value
	input  wire logic [PORT_D_WIDTH-1:0] port_d_dir,          // port D drive enable
	input  wire logic [PORT_D_WIDTH-1:0] port_d_pull,         // port D pull-up request
	output logic [PORT_B_WIDTH-1:0]      port_b_pins_o,       // port B pin output
	output logic [PORT_B_WIDTH-1:0]      port_b_pins_oe,      // port B output enable
	output logic [PORT_B_WIDTH-1:0]      port_b_pu_en,        // port B pull-up enable
	output logic [PORT_C_WIDTH-1:0]      port_c_pins_o,       // port C pin output
	output logic [PORT_C_WIDTH-1:0]      port_c_pins_oe,      // port C output enable
	output logic [PORT_C_WIDTH-1:0]      port_c_pu_en,        // port C pull-up enable
	output logic [PORT_D_WIDTH-1:0]      port_d_pins_o,       // port D pin output
	output logic [PORT_D_WIDTH-1:0]      port_d_pins_oe,      // port D output enable
	output logic [PORT_D_WIDTH-1:0]      port_d_pu_en,        // port D pull-up enable
	output logic [PORT_B_WIDTH-1:0]      port_b_sync,         // port B synchronised input
	output logic [PORT_C_WIDTH-1:0]      port_c_sync,         // port C synchronised input
	output logic [PORT_D_WIDTH-1:0]      port_d_sync,         // port D synchronised input
	output logic                         tosc_route,          // PB7..6 feed async timer
	output logic                         cpu_clk_en,          // processor clock enable
	output logic                         io_clk_en,           // timers, SPI, interrupts
	output logic                         adc_clk_en,          // converter clock enable
	output logic                         async_clk_en,        // async timer enable
	output logic                         main_osc_en,         // main oscillator enable
	output logic                         sleeping,            // in a sleep mode
	output logic                         sys_reset            // chip reset request
);
	// ==========================================
	// reset release and pin synchronisers
	logic       rst_s1_reg;
	logic       rst_s2_reg;
	logic       srst_n;
	logic [PORT_B_WIDTH-1:0] b_s1_reg;
	logic [PORT_B_WIDTH-1:0] b_s2_reg;
	logic [PORT_C_WIDTH-1:0] c_s1_reg;
	logic [PORT_C_WIDTH-1:0] c_s2_reg;
	logic [PORT_D_WIDTH-1:0] d_s1_reg;
	logic [PORT_D_WIDTH-1:0] d_s2_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign srst_n = rst_s2_reg;

	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			b_s1_reg <= ZERO8;
			b_s2_reg <= ZERO8;
			c_s1_reg <= 7'h7F;
			c_s2_reg <= 7'h7F;
			d_s1_reg <= ZERO8;
			d_s2_reg <= ZERO8;
		end else if (clk_en) begin
			b_s1_reg <= port_b_in;
			b_s2_reg <= b_s1_reg;
			c_s1_reg <= port_c_in;
			c_s2_reg <= c_s1_reg;
			d_s1_reg <= port_d_in;
			d_s2_reg <= d_s1_reg;
		end
	end

	// ==========================================
	// reset pin filter
	logic reset_pin_low;
	logic ext_reset;
	assign reset_pin_low = !reset_pin_disable_fuse && !c_s2_reg[SHARED_PIN_BIT];

	reset_pulse_filter u_filter (
		.ref_clk   (ref_clk),
		.rst_n     (srst_n),
		.clk_en    (clk_en),
		.pin_low   (reset_pin_low),
		.ext_reset (ext_reset)
	);

	// ==========================================
	// sleep state machine
	typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} pm_state_t;
	pm_state_t   state_reg;
	pm_state_t   state_next;
	sleep_mode_t mode_reg;
	sleep_mode_t mode_next;
	logic        cpu_next;
	logic        io_next;
	logic        adc_next;
	logic        async_next;
	logic        osc_next;

	always_comb begin
		state_next = state_reg;
		mode_next  = mode_reg;
		case (state_reg)
			ST_RUN: begin
				if (sleep_req && sleep_mode_sel < 3'(NUM_MODES)) begin
					mode_next  = sleep_mode_t'(sleep_mode_sel);
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_irq || ext_reset)
					state_next = ST_WAKE;
			end
			ST_WAKE: state_next = ST_RUN;
			default: state_next = ST_RUN;
		endcase
	end

	always_comb begin
		cpu_next   = 1'b1;
		io_next    = 1'b1;
		adc_next   = 1'b1;
		async_next = 1'b1;
		osc_next   = 1'b1;
		if (state_next == ST_SLEEP) begin
			cpu_next = 1'b0;
			case (mode_next)
				MODE_IDLE: ;
				MODE_ADC_NR: io_next = 1'b0;
				MODE_PWR_DOWN: begin
					io_next    = 1'b0;
					adc_next   = 1'b0;
					async_next = 1'b0;
					osc_next   = 1'b0;
				end
				MODE_PWR_SAVE: begin
					io_next  = 1'b0;
					adc_next = 1'b0;
					osc_next = 1'b0;
				end
				MODE_STANDBY: begin
					io_next    = 1'b0;
					adc_next   = 1'b0;
					async_next = 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			state_reg    <= ST_RUN;
			mode_reg     <= MODE_IDLE;
			cpu_clk_en   <= 1'b1;
			io_clk_en    <= 1'b1;
			adc_clk_en   <= 1'b1;
			async_clk_en <= 1'b1;
			main_osc_en  <= 1'b1;
			sleeping     <= 1'b0;
		end else if (clk_en) begin
			state_reg    <= state_next;
			mode_reg     <= mode_next;
			cpu_clk_en   <= cpu_next;
			io_clk_en    <= io_next;
			adc_clk_en   <= adc_next;
			async_clk_en <= async_next;
			main_osc_en  <= osc_next;
			sleeping     <= (state_next == ST_SLEEP);
		end
	end

	// ==========================================
	// port pin control, tri-stated in reset
	logic in_reset;
	assign in_reset = ext_reset;
	logic tosc_next;
	assign tosc_next = int_rc_clock && async_timer_clock_select;

	logic [PORT_B_WIDTH-1:0] b_oe_next;
	logic [PORT_C_WIDTH-1:0] c_oe_next;
	logic [PORT_D_WIDTH-1:0] d_oe_next;
	always_comb begin
		b_oe_next = in_reset ? ZERO8 : port_b_dir;
		if (tosc_next) begin
			b_oe_next[TOSC1_BIT] = 1'b0;
			b_oe_next[TOSC2_BIT] = 1'b0;
		end
		c_oe_next = in_reset ? 7'h00 : port_c_dir;
		if (!reset_pin_disable_fuse)
			c_oe_next[SHARED_PIN_BIT] = 1'b0;
		d_oe_next = in_reset ? ZERO8 : port_d_dir;
	end

	always_ff @(posedge ref_clk or negedge srst_n) begin
		if (!srst_n) begin
			port_b_pins_o  <= ZERO8;
			port_b_pins_oe <= ZERO8;
			port_b_pu_en   <= ZERO8;
			port_c_pins_o  <= 7'h00;
			port_c_pins_oe <= 7'h00;
			port_c_pu_en   <= 7'h00;
			port_d_pins_o  <= ZERO8;
			port_d_pins_oe <= ZERO8;
			port_d_pu_en   <= ZERO8;
			port_b_sync    <= ZERO8;
			port_c_sync    <= 7'h00;
			port_d_sync    <= ZERO8;
			tosc_route     <= 1'b0;
			sys_reset      <= 1'b0;
		end else if (clk_en) begin
			port_b_pins_o  <= port_b_out;
			port_b_pins_oe <= b_oe_next;
			port_b_pu_en   <= in_reset ? ZERO8 : (port_b_pull & ~port_b_dir);
			port_c_pins_o  <= port_c_out;
			port_c_pins_oe <= c_oe_next;
			port_c_pu_en   <= in_reset ? 7'h00 : (port_c_pull & ~port_c_dir);
			port_d_pins_o  <= port_d_out;
			port_d_pins_oe <= d_oe_next;
			port_d_pu_en   <= in_reset ? ZERO8 : (port_d_pull & ~port_d_dir);
			port_b_sync    <= b_s2_reg;
			port_c_sync    <= c_s2_reg;
			port_d_sync    <= d_s2_reg;
			tosc_route     <= tosc_next;
			sys_reset      <= ext_reset;
		end
	end

	// ==========================================
	// checks
	AST_IDLE_KEEPS_IO: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && state_next == ST_SLEEP && mode_next == MODE_IDLE) |=> (io_clk_en && !cpu_clk_en))
		else $error("idle gated the peripherals");
	AST_PDOWN_OSC_OFF: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && state_next == ST_SLEEP && mode_next == MODE_PWR_DOWN) |=> !main_osc_en)
		else $error("oscillator ran in power-down");
	AST_PSAVE_ASYNC: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && state_next == ST_SLEEP && mode_next == MODE_PWR_SAVE) |=> (async_clk_en && !io_clk_en))
		else $error("power-save lost the async timer");
	AST_ADC_NR: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && state_next == ST_SLEEP && mode_next == MODE_ADC_NR) |=> (adc_clk_en && !io_clk_en))
		else $error("adc noise mode clock wrong");
	AST_STANDBY_OSC: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && state_next == ST_SLEEP && mode_next == MODE_STANDBY) |=> (main_osc_en && !async_clk_en))
		else $error("standby stopped the oscillator");
	AST_RESET_TRISTATE: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && ext_reset) |=> (port_b_pins_oe == ZERO8 && port_d_pins_oe == ZERO8 && port_c_pins_oe == 7'h00))
		else $error("pins driven during reset");
	AST_RESET_PIN: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && ext_reset) |=> sys_reset)
		else $error("long low did not reset");
	AST_FUSE_IO: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && reset_pin_disable_fuse) |=> !ext_reset)
		else $error("fused pin acted as reset");
	AST_TOSC: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && int_rc_clock && async_timer_clock_select) |=> (tosc_route && !port_b_pins_oe[TOSC1_BIT]))
		else $error("timer oscillator pins not routed");
	AST_WAKE: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && state_reg == ST_SLEEP && wake_irq) ##1 clk_en |=> (cpu_clk_en && !sleeping))
		else $error("wake-up did not resume");
endmodule

// File: verif/reset_source_model.sv
// partner model of the external reset source on the shared pin
`timescale 1ns/1ps
module reset_source_model (
	input  wire logic        ref_clk,   // system clock
	input  wire logic        pulse_go,  // start one low pulse
	input  wire logic [15:0] pulse_len, // low time in cycles
	output logic             pin_level  // shared pin level
);
	int left = 0;

	// ==========================================
	// low pulse held for the commanded count, then back to the pull-up level
	initial pin_level = 1'b1;
	always @(posedge ref_clk) begin
		if (left > 0) begin
			left--;
		end else if (pulse_go) begin
			left = int'(pulse_len);
		end
		#1;
		pin_level = (left == 0);
	end
endmodule

// File: verif/test_sleep_reset_ctrl.sv
// self-checking bench for the sleep mode and reset pin controller
`timescale 1ns/1ps
module test_sleep_reset_ctrl;
	import sleep_pkg::*;
	typedef struct {int due; int kind; logic [31:0] exp;} note_t;
	logic        ref_clk, rst_n, clk_en, sleep_req, wake_irq, pulse_go, pin_level;
	logic        reset_pin_disable_fuse, int_rc_clock, async_timer_clock_select;
	logic [2:0]  sleep_mode_sel;
	logic [7:0]  port_b_in, port_b_out, port_b_dir, port_b_pull, port_d_in, port_d_out;
	logic [7:0]  port_d_dir, port_d_pull, port_b_pins_o, port_b_pins_oe, port_b_pu_en;
	logic [7:0]  port_d_pins_o, port_d_pins_oe, port_d_pu_en, port_b_sync, port_d_sync;
	logic [6:0]  port_c_in, port_c_out, port_c_dir, port_c_pull, port_c_pins_o;
	logic [6:0]  port_c_pins_oe, port_c_pu_en, port_c_sync;
	logic [5:0]  c_low;
	logic        tosc_route, cpu_clk_en, io_clk_en, adc_clk_en, async_clk_en;
	logic        main_osc_en, sleeping, sys_reset;
	logic [15:0] rnd, pulse_len;
	logic [95:0] pool;
	int          cyc = 0;
	int          n_errors = 0;
	int          cmp_count = 0;
	note_t       q[$];
	note_t       nt;
	logic [5:0]  mode_tab [6] = '{6'h1F, 6'h0F, 6'h01, 6'h05, 6'h03, 6'h3E};

	assign port_c_in = {pin_level, c_low};
	sleep_reset_ctrl dut (
		.ref_clk, .rst_n, .clk_en, .sleep_req, .sleep_mode_sel, .wake_irq,
		.reset_pin_disable_fuse, .int_rc_clock, .async_timer_clock_select,
		.port_b_in, .port_c_in, .port_d_in, .port_b_out, .port_b_dir, .port_b_pull,
		.port_c_out, .port_c_dir, .port_c_pull, .port_d_out, .port_d_dir, .port_d_pull,
		.port_b_pins_o, .port_b_pins_oe, .port_b_pu_en, .port_c_pins_o, .port_c_pins_oe,
		.port_c_pu_en, .port_d_pins_o, .port_d_pins_oe, .port_d_pu_en, .port_b_sync,
		.port_c_sync, .port_d_sync, .tosc_route, .cpu_clk_en, .io_clk_en, .adc_clk_en,
		.async_clk_en, .main_osc_en, .sleeping, .sys_reset
	);
	reset_source_model partner (.ref_clk, .pulse_go, .pulse_len, .pin_level);

	// ==========================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] obs(int kind);
		case (kind)
			0: return {26'h0, cpu_clk_en, io_clk_en, adc_clk_en, async_clk_en, main_osc_en, sleeping};
			1: return {port_b_pins_o, port_b_pins_oe, port_b_pu_en, port_b_sync};
			2: return {4'h0, port_c_pins_o, port_c_pins_oe, port_c_pu_en, port_c_sync};
			3: return {port_d_pins_o, port_d_pins_oe, port_d_pu_en, port_d_sync};
			default: return {30'h0, sys_reset, tosc_route};
		endcase
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: kind %0d seen %h expected %h", $time, nt.kind, seen, exp);
		end
	endtask
	task automatic note(int k, int kind, logic [31:0] e);
		q.push_back(note_t'{cyc + k, kind, e});
	endtask
	task automatic step(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic pin_notes(int k, logic rs, logic c6);
		logic [6:0] c_oe;
		logic [7:0] b_mask;
		c_oe = rs ? 7'h00 : (port_c_dir & (reset_pin_disable_fuse ? 7'h7F : 7'h3F));
		b_mask = (int_rc_clock && async_timer_clock_select) ? 8'h3F : 8'hFF;
		note(k, 1, {port_b_out, rs ? 8'h00 : port_b_dir & b_mask,
			rs ? 8'h00 : port_b_pull & ~port_b_dir,
			port_b_in});
		note(k, 2, {4'h0, port_c_out, c_oe, rs ? 7'h00 : port_c_pull & ~port_c_dir, c6, c_low});
		note(k, 3, {port_d_out, rs ? 8'h00 : port_d_dir, rs ? 8'h00 : port_d_pull & ~port_d_dir,
			port_d_in});
	endtask
	task automatic pin_pulse(int len, logic fz, logic hit);
		reset_pin_disable_fuse = fz;
		pulse_len = 16'(len);
		pulse_go = 1'b1;
		step(1);
		pulse_go = 1'b0;
		note(len - 6, 4, {30'h0, hit, 1'b0});
		pin_notes(len - 6, hit, 1'b0);
		step(len + 20);
		note(1, 4, 32'h0);
		pin_notes(1, 1'b0, 1'b1);
		step(2);
		$display("reset pin pulse of %0d cycles done", len);
	endtask
	task automatic close_out();
		if (q.size() > 0) begin
			n_errors++;
			$display("ERROR at %0t: %0d expected results never seen", $time, q.size());
		end
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================
	// clock, cycle count, timeout and result watcher
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			$display("ERROR at %0t: run timed out", $time);
			close_out();
		end
	end
	always @(posedge ref_clk) begin
		#2;
		while (q.size() > 0 && q[0].due <= cyc) begin
			nt = q.pop_front();
			case (nt.kind)
				0: check(obs(0), nt.exp);
				1: check(obs(1), nt.exp);
				2: check(obs(2), nt.exp);
				3: check(obs(3), nt.exp);
				default: check(obs(4), nt.exp);
			endcase
		end
	end

	// ==========================================
	// main sequence
	initial begin
		{rst_n, sleep_req, wake_irq, pulse_go, int_rc_clock, async_timer_clock_select} = '0;
		{reset_pin_disable_fuse, sleep_mode_sel, c_low, pulse_len} = '0;
		{port_b_in, port_b_out, port_b_dir, port_b_pull, port_d_in, port_d_out} = '0;
		{port_d_dir, port_d_pull, port_c_out, port_c_dir, port_c_pull} = '0;
		clk_en = 1'b1;
		rnd = 16'h0013;
		step(6);
		rst_n = 1'b1;
		step(3);
		note(2, 0, 32'h3E);
		note(2, 4, 32'h0);
		step(3);
		for (int m = 0; m < 6; m++) begin
			sleep_mode_sel = 3'(m);
			sleep_req = 1'b1;
			step(1);
			sleep_req = 1'b0;
			note(3, 0, {26'h0, mode_tab[m]});
			step(4);
			wake_irq = 1'b1;
			step(1);
			wake_irq = 1'b0;
			note(3, 0, 32'h3E);
			step(4);
			$display("sleep mode select %0d done", m);
		end
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 6; j++) begin
				rnd = lfsr(rnd);
				pool = {pool[79:0], rnd};
			end
			{port_b_out, port_b_dir, port_b_pull, port_b_in, port_c_out, port_c_dir, port_c_pull,
				c_low, port_d_out, port_d_dir, port_d_pull, port_d_in,
				reset_pin_disable_fuse} = pool[91:0];
			port_c_pull[6] = port_c_pull[6] & reset_pin_disable_fuse;
			pin_notes(5, 1'b0, 1'b1);
			step(6);
		end
		$display("random pin drive done");
		for (int t = 0; t < 4; t++) begin
			{int_rc_clock, async_timer_clock_select} = 2'(t);
			note(3, 4, {30'h0, 1'b0, t == 3});
			pin_notes(3, 1'b0, 1'b1);
			step(4);
		end
		{int_rc_clock, async_timer_clock_select} = 2'b00;
		$display("timer oscillator routing done");
		clk_en = 1'b0;
		sleep_req = 1'b1;
		sleep_mode_sel = 3'h2;
		note(2, 0, 32'h3E);
		step(3);
		clk_en = 1'b1;
		sleep_req = 1'b0;
		step(2);
		$display("clock enable freeze done");
		pin_pulse(100, 1'b0, 1'b0);
		pin_pulse(420, 1'b1, 1'b0);
		sleep_req = 1'b1;
		step(1);
		sleep_req = 1'b0;
		note(2, 0, 32'h01);
		step(3);
		pin_pulse(420, 1'b0, 1'b1);
		note(1, 0, 32'h3E);
		step(3);
		close_out();
	end
endmodule
